// ===== logic/ftcr_pkg.sv
// Overview of operation
// - offset word is low register bits 15:0 plus high register bits 9:0 on top.
// - the 26-bit offset word is signed two's complement.
// - after reset every offset word bit is zero, nominal frequency.
// - committed offset changes only on a high register write; low writes are held.
// - high register bits 15:11 read zero and ignore writes.
// - high register bit 10 enables the output driver, resets to zero.
// - software enable bit only acts in software output control mode.
// - pull range is read-write in register 0x02 bits 3:0.
// - pull range register bits 15:4 read zero and ignore writes.
// - range codes ascend 0000 smallest to 1111 largest; reset value factory set.
// - offset word full scale 2^25-1 means positive full pull of the range.
package ftcr_pkg;
   localparam int FTCR_ADDR_W = 8;
   localparam int FTCR_DATA_W = 16;
   localparam int FTCR_WORD_W = 26;
   localparam int FTCR_HIGH_W = 10;
   localparam int FTCR_RANGE_W = 4;
   localparam logic [7:0] FTCR_OFS_LOW = 8'h00;
   localparam logic [7:0] FTCR_OFS_HIGH = 8'h01;
   localparam logic [7:0] FTCR_OFS_RANGE = 8'h02;
   localparam int FTCR_OE_BIT = 10;
   localparam logic [15:0] FTCR_LOW_RST = 16'h0000;
   localparam logic [9:0] FTCR_HIGH_RST = 10'h000;
   localparam logic FTCR_OE_RST = 1'b0;
   localparam logic [3:0] FTCR_RANGE_DFLT = 4'h9;
   localparam logic [25:0] FTCR_FULL_SCALE = 26'h1FF_FFFF;
endpackage : ftcr_pkg

// ===== logic/ftcr_regs.sv
`timescale 1ns/100ps
module ftcr_regs
   import ftcr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [FTCR_ADDR_W-1:0] i_addr,
   input wire logic [FTCR_DATA_W-1:0] i_wdata,
   input wire logic i_sw_oe_mode,
   input wire logic i_oe_pin,
   input wire logic [FTCR_RANGE_W-1:0] i_range_strap,
   output logic [FTCR_DATA_W-1:0] o_rdata,
   output logic o_rd_valid,
   output logic signed [FTCR_WORD_W-1:0] o_freq_offset_word,
   output logic o_freq_update,
   output logic [FTCR_RANGE_W-1:0] o_pull_range,
   output logic o_out_enable
);
   logic [15:0] freq_offset_low;
   logic [9:0] freq_offset_high;
   logic sw_oe;
   logic strap_done;
   logic [15:0] next_rdata;
   logic wr_low;
   logic wr_high;
   logic wr_range;
   logic rd_low;
   logic rd_high;
   logic rd_range;

   // one comparator shape for every strobe, keeps write and read decode in step
   function automatic logic addr_hit(input logic [FTCR_ADDR_W-1:0] addr,
      input logic [FTCR_ADDR_W-1:0] ofs);
      return addr == ofs;
   endfunction : addr_hit

   assign wr_low = i_wr_en && addr_hit(i_addr, FTCR_OFS_LOW);
   assign wr_high = i_wr_en && addr_hit(i_addr, FTCR_OFS_HIGH);
   assign wr_range = i_wr_en && addr_hit(i_addr, FTCR_OFS_RANGE);
   assign rd_low = i_rd_en && addr_hit(i_addr, FTCR_OFS_LOW);
   assign rd_high = i_rd_en && addr_hit(i_addr, FTCR_OFS_HIGH);
   assign rd_range = i_rd_en && addr_hit(i_addr, FTCR_OFS_RANGE);

   // low part only held; reaches the output on the high write
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         freq_offset_low <= FTCR_LOW_RST;
      else if (i_clk_en && wr_low)
         freq_offset_low <= i_wdata;

   // bits 15:11 never stored
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         freq_offset_high <= FTCR_HIGH_RST;
      else if (i_clk_en && wr_high)
         freq_offset_high <= i_wdata[FTCR_HIGH_W-1:0];

   // in pin mode the bit keeps its value so the write has no effect
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         sw_oe <= FTCR_OE_RST;
      else if (i_clk_en && wr_high && i_sw_oe_mode)
         sw_oe <= i_wdata[FTCR_OE_BIT];

   // committed word: signed, scaled downstream with FTCR_FULL_SCALE as +full pull
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
      begin
         o_freq_offset_word <= '0;
         o_freq_update <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_freq_update <= wr_high;
         if (wr_high)
            o_freq_offset_word <= {i_wdata[FTCR_HIGH_W-1:0], freq_offset_low};
      end

   // factory strap caught after reset release, a reset cannot sample a port
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
      begin
         o_pull_range <= FTCR_RANGE_DFLT;
         strap_done <= 1'b0;
      end
      else if (i_clk_en)
      begin
         strap_done <= 1'b1;
         if (wr_range)
            o_pull_range <= i_wdata[FTCR_RANGE_W-1:0];
         else if (!strap_done)
            o_pull_range <= i_range_strap;
      end

   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         o_out_enable <= 1'b0;
      else if (i_clk_en)
         o_out_enable <= i_sw_oe_mode ? (wr_high ? i_wdata[FTCR_OE_BIT] : sw_oe) : i_oe_pin;

   always_comb
   begin
      next_rdata = '0;
      unique case (i_addr)
         FTCR_OFS_LOW: next_rdata = freq_offset_low;
         FTCR_OFS_HIGH: next_rdata = {5'h0, sw_oe, freq_offset_high};
         FTCR_OFS_RANGE: next_rdata = {12'h000, o_pull_range};
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
      begin
         o_rdata <= '0;
         o_rd_valid <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en)
            o_rdata <= next_rdata;
      end

   // handshake steps shared by the readback and commit checks
   sequence low_write_s;
      i_clk_en && wr_low;
   endsequence : low_write_s

   sequence low_read_s;
      i_clk_en && rd_low;
   endsequence : low_read_s

   sequence high_write_s;
      i_clk_en && wr_high;
   endsequence : high_write_s

   sequence high_read_s;
      i_clk_en && rd_high;
   endsequence : high_read_s

   commit_only_high_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !wr_high) |=> $stable(o_freq_offset_word))
      else $error("offset word changed without high write");

   commit_value_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      high_write_s |=> o_freq_offset_word == {$past(i_wdata[9:0]),
      $past(freq_offset_low)})
      else $error("committed word wrong");

   update_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      high_write_s |=> o_freq_update)
      else $error("update pulse missing");

   update_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !wr_high) |=> !o_freq_update)
      else $error("update pulse without high write");

   pin_mode_oe_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !i_sw_oe_mode) |=> $stable(sw_oe))
      else $error("soft enable changed in pin mode");

   pin_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !i_sw_oe_mode) |=> o_out_enable == $past(i_oe_pin))
      else $error("driver enable not following pin");

   high_reserved_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && rd_high) |=> o_rdata[15:11] == 5'h00)
      else $error("high reserved bits nonzero");

   range_reserved_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && rd_range) |=> o_rdata[15:4] == 12'h000)
      else $error("range reserved bits nonzero");

   range_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && wr_range) |=> o_pull_range == $past(i_wdata[3:0]))
      else $error("range write lost");

   range_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && strap_done && !wr_range) |=> $stable(o_pull_range))
      else $error("range changed without write");

   strap_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !strap_done && !wr_range)
      |=> o_pull_range == $past(i_range_strap))
      else $error("factory range not captured");

   low_readback_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      low_write_s ##1 !wr_low ##1 low_read_s |=> o_rdata == $past(i_wdata, 3))
      else $error("low readback wrong");

   high_readback_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      high_write_s ##1 !wr_high ##1 high_read_s
      |=> o_rdata[9:0] == $past(i_wdata[9:0], 3))
      else $error("high readback wrong");

   oe_soft_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_sw_oe_mode && wr_high) |=> o_out_enable == $past(i_wdata[10]))
      else $error("soft enable not applied");

   oe_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_sw_oe_mode && !wr_high) |=> o_out_enable == $past(sw_oe))
      else $error("soft enable not held");

   read_valid_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_clk_en |=> o_rd_valid == $past(i_rd_en))
      else $error("read valid pulse wrong");

   unmapped_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_rd_en && !rd_low && !rd_high && !rd_range)
      |=> o_rdata == 16'h0000)
      else $error("unmapped read nonzero");

   // a low clock enable must leave the offset word, pull range, driver enable and read valid untouched
   state_freeze_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_clk_en |=> $stable(o_freq_offset_word) && $stable(o_pull_range)
      && $stable(o_out_enable) && $stable(o_rd_valid))
      else $error("state moved with clock enable low");
endmodule : ftcr_regs

// ===== test/ftcr_master.sv
`timescale 1ns/100ps
module ftcr_master
   import ftcr_pkg::*;
(
   input wire logic i_ref_clk,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [FTCR_ADDR_W-1:0] o_addr,
   output logic [FTCR_DATA_W-1:0] o_wdata
);
   initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
      // commits spaced out, keeps update rate low
      if (wr && a == FTCR_OFS_HIGH)
         repeat (660) @(negedge i_ref_clk);
      @(negedge i_ref_clk);
      o_wr_en = wr;
      o_rd_en = !wr;
      o_addr = a;
      o_wdata = d;
      @(negedge i_ref_clk);
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      // stale data inverted so nothing can lean on it
      o_wdata = ~d;
   endtask : acc
endmodule : ftcr_master

// ===== test/tb_freq_trim_control_regs.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, a); end end
module tb_freq_trim_control_regs;
   import ftcr_pkg::*;
   logic ref_clk, rst, wr_en, rd_en, rd_valid, freq_update, out_enable;
   logic sw_oe_mode = 1'b1;
   logic oe_pin = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] range_strap = 4'h5;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [3:0] pull_range;
   logic signed [FTCR_WORD_W-1:0] word;
   int comparisons = 0;
   int miscompares = 0;
   ftcr_master i_mst (.i_ref_clk(ref_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
      .o_wdata(wdata));
   ftcr_regs i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_clk_en(clk_en), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_sw_oe_mode(sw_oe_mode),
      .i_oe_pin(oe_pin), .i_range_strap(range_strap), .o_rdata(rdata), .o_rd_valid(rd_valid),
      .o_freq_offset_word(word), .o_freq_update(freq_update), .o_pull_range(pull_range),
      .o_out_enable(out_enable));
   task results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   task rd(input logic [7:0] a, input logic [15:0] e);
      i_mst.acc(1'b0, a, 16'h0000);
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rdata", e, rdata)
   endtask : rd
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial
   begin
      #400000;
      miscompares++;
      results();
   end
   initial
   begin
      rst = 1'b1;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      `CHK("range", 4'h5, pull_range)
      `CHK("word", 26'h000_0000, word)
      `CHK("oe", 1'b0, out_enable)
      rd(FTCR_OFS_LOW, 16'h0000);
      i_mst.acc(1'b1, FTCR_OFS_LOW, 16'h1234);
      `CHK("update", 1'b0, freq_update)
      `CHK("held", 26'h000_0000, word)
      i_mst.acc(1'b1, FTCR_OFS_HIGH, 16'hFFFF);
      `CHK("update", 1'b1, freq_update)
      `CHK("word", 26'h3FF_1234, word)
      `CHK("sign", 1'b1, word < 0)
      `CHK("oe", 1'b1, out_enable)
      rd(FTCR_OFS_HIGH, 16'h07FF);
      `CHK("update end", 1'b0, freq_update)
      rd(FTCR_OFS_LOW, 16'h1234);
      sw_oe_mode = 1'b0;
      i_mst.acc(1'b1, FTCR_OFS_HIGH, 16'h0001);
      rd(FTCR_OFS_HIGH, 16'h0401);
      `CHK("pin oe", 1'b0, out_enable)
      oe_pin = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("pin oe", 1'b1, out_enable)
      i_mst.acc(1'b1, FTCR_OFS_LOW, 16'hFFFF);
      i_mst.acc(1'b1, FTCR_OFS_HIGH, 16'h01FF);
      `CHK("full", FTCR_FULL_SCALE, word)
      `CHK("positive", 1'b1, word > 0)
      i_mst.acc(1'b1, FTCR_OFS_LOW, 16'hABCD);
      rd(FTCR_OFS_LOW, 16'hABCD);
      `CHK("held", FTCR_FULL_SCALE, word)
      for (int i = 0; i < 16; i++)
      begin
         i_mst.acc(1'b1, FTCR_OFS_RANGE, {12'hFFF, 4'(i)});
         `CHK("range", 4'(i), pull_range)
         rd(FTCR_OFS_RANGE, {12'h000, 4'(i)});
      end
      rd(8'h03, 16'h0000);
      clk_en = 1'b0;
      i_mst.acc(1'b1, FTCR_OFS_RANGE, 16'h0002);
      `CHK("frozen", 4'hF, pull_range)
      clk_en = 1'b1;
      rd(FTCR_OFS_RANGE, 16'h000F);
      range_strap = 4'hC;
      sw_oe_mode = 1'b1;
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      `CHK("range", 4'hC, pull_range)
      `CHK("word", 26'h000_0000, word)
      `CHK("oe", 1'b0, out_enable)
      rd(FTCR_OFS_HIGH, 16'h0000);
      results();
   end
endmodule : tb_freq_trim_control_regs
